// ### rfbc_bias_ctrl.v
// Behaviour
// RULE1: pin driven only while enable is 1; otherwise released (high impedance).
// RULE2: when enabled, level set by topology first, then by transmit or receive.
// RULE3: single port ignores polarity swap; high in transmit, low in receive.
// RULE4: dual port: transmit 1, receive 0; polarity swap exchanges both levels.
// RULE5: pin has a defined state in idle, hibernate, doze, receive and transmit.
// RULE6: idle and low-power states drive low when enabled, released when disabled.
// RULE7: enable is control bit 14, reset 0, so pin starts released.
// RULE8: polarity swap is control bit 13, reset 0, used in dual port only.
// RULE9: topology is control bit 12: 0 dual port (reset), 1 single port.
`timescale 1ns/10ps
`default_nettype none
`include "rfbc_defines.vh"

module rfbc_bias_ctrl (
  input  wire                          core_clk,
  input  wire                          rst,
  input  wire [`RFBC_CTRL_WIDTH-1:0]   ctrlWrData,
  input  wire                          ctrlWrEn,
  input  wire                          rxActive,
  input  wire                          txActive,
  output wire                          rf_ctrl_out,
  output wire                          rfCtrlOutOe,
  output wire                          rf_ctrl_out_enable,
  output wire                          rf_ctrl_out_polarity_swap,
  output wire                          port_topology_select,
  output wire [`RFBC_ST_WIDTH-1:0]     activityState
);

  localparam [`RFBC_ST_WIDTH-1:0] ST_IDLE = `RFBC_ST_IDLE;
  localparam [`RFBC_ST_WIDTH-1:0] ST_RX   = `RFBC_ST_RX;
  localparam [`RFBC_ST_WIDTH-1:0] ST_TX   = `RFBC_ST_TX;

  reg                       enable_ff;
  reg                       polSwap_ff;
  reg                       topology_ff;
  reg [`RFBC_ST_WIDTH-1:0]  state_ff;
  reg [`RFBC_ST_WIDTH-1:0]  nxt_state;
  reg                       pinLevel_ff;
  reg                       pinDrive_ff;
  wire                      decDrive;
  wire                      decLevel;

  // --------------------------------------------------------------------------
  // control bits
  // --------------------------------------------------------------------------
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      enable_ff   <= `RFBC_OUT_ENABLE_RST; // RULE7
      polSwap_ff  <= `RFBC_POL_SWAP_RST; // RULE8
      topology_ff <= `RFBC_TOPOLOGY_RST; // RULE9
    end else if (ctrlWrEn) begin
      enable_ff   <= ctrlWrData[`RFBC_OUT_ENABLE_BIT]; // RULE7
      polSwap_ff  <= ctrlWrData[`RFBC_POL_SWAP_BIT]; // RULE8
      topology_ff <= ctrlWrData[`RFBC_TOPOLOGY_BIT]; // RULE9
    end
  end

  // --------------------------------------------------------------------------
  // radio activity tracking
  // --------------------------------------------------------------------------
  always @* begin
    nxt_state = ST_IDLE;
    case (1'h1)
      txActive: nxt_state = ST_TX;
      rxActive: nxt_state = ST_RX;
      default:  nxt_state = ST_IDLE; // RULE5
    endcase
  end

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_ff <= ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // --------------------------------------------------------------------------
  // output level
  // --------------------------------------------------------------------------
  rfbc_level_decode u_decode (
    .enable       (enable_ff),
    .singlePort   (topology_ff == `RFBC_TOPOLOGY_SINGLE), // RULE2
    .polaritySwap (polSwap_ff),
    .rxState      (state_ff == ST_RX),
    .txState      (state_ff == ST_TX),
    .drive        (decDrive),
    .level        (decLevel)
  );

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pinDrive_ff <= 1'h0; // RULE7
      pinLevel_ff <= 1'h0;
    end else begin
      pinDrive_ff <= decDrive; // RULE1 RULE5
      pinLevel_ff <= decLevel; // RULE2 RULE6
    end
  end

  assign rf_ctrl_out               = pinLevel_ff;
  assign rfCtrlOutOe               = pinDrive_ff;
  assign rf_ctrl_out_enable        = enable_ff;
  assign rf_ctrl_out_polarity_swap = polSwap_ff;
  assign port_topology_select      = topology_ff;
  assign activityState             = state_ff;

endmodule // rfbc_bias_ctrl

`default_nettype wire

// ### rfbc_defines.vh
`ifndef RFBC_DEFINES_VH
`define RFBC_DEFINES_VH

// ----------------------------------------------------------------------------
// control word layout
// ----------------------------------------------------------------------------
`define RFBC_CTRL_WIDTH      16
`define RFBC_OUT_ENABLE_BIT  14
`define RFBC_POL_SWAP_BIT    13
`define RFBC_TOPOLOGY_BIT    12

// ----------------------------------------------------------------------------
// reset values and topology encodings
// ----------------------------------------------------------------------------
`define RFBC_OUT_ENABLE_RST  1'h0
`define RFBC_POL_SWAP_RST    1'h0
`define RFBC_TOPOLOGY_RST    1'h0
`define RFBC_TOPOLOGY_DUAL   1'h0
`define RFBC_TOPOLOGY_SINGLE 1'h1

// ----------------------------------------------------------------------------
// activity states, one-hot
// ----------------------------------------------------------------------------
`define RFBC_ST_WIDTH        3
`define RFBC_ST_IDLE         3'h1
`define RFBC_ST_RX           3'h2
`define RFBC_ST_TX           3'h4

`endif

// ### rfbc_level_decode.v
`timescale 1ns/10ps
`default_nettype none

// ----------------------------------------------------------------------------
// level decode for the front-end control pin
// ----------------------------------------------------------------------------
module rfbc_level_decode (
  input  wire enable,
  input  wire singlePort,
  input  wire polaritySwap,
  input  wire rxState,
  input  wire txState,
  output reg  drive,
  output reg  level
);

  always @* begin
    drive = enable; // RULE1
    level = 1'h0;
    if (!enable) begin
      level = 1'h0; // RULE1
    end else if (singlePort) begin
      level = txState; // RULE3
    end else if (txState || rxState) begin
      level = txState ^ polaritySwap; // RULE4 RULE8
    end else begin
      level = 1'h0; // RULE6
    end
  end

endmodule // rfbc_level_decode

`default_nettype wire

// ### rfbc_far_end.sv
`timescale 1ns/10ps
`default_nettype none
module rfbc_far_end (
  input  wire logic core_clk,
  input  wire logic outLvl,
  input  wire logic outOe,
  output var logic  pinLvl
);
  logic last_ff = 1'h0;
  always @(posedge core_clk) if (outOe) last_ff <= outLvl;
  assign pinLvl = outOe ? outLvl : ~last_ff;
endmodule // rfbc_far_end
`default_nettype wire

// ### rfbc_bias_ctrl_sva.sv
`timescale 1ns/10ps
`default_nettype none
module rfbc_chk (
  input wire logic        core_clk,
  input wire logic        rst,
  input wire logic [15:0] ctrlWrData,
  input wire logic        ctrlWrEn,
  input wire logic        rxActive,
  input wire logic        txActive,
  input wire logic        rf_ctrl_out,
  input wire logic        rfCtrlOutOe,
  input wire logic        rf_ctrl_out_enable,
  input wire logic        rf_ctrl_out_polarity_swap,
  input wire logic        port_topology_select,
  input wire logic [2:0]  activityState
);
  wire       en = rf_ctrl_out_enable;
  wire       sw = rf_ctrl_out_polarity_swap;
  wire       tp = port_topology_select;
  wire [2:0] st = activityState;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  en_bit_a: assert property (ctrlWrEn |=> en == $past(ctrlWrData[14]))
    else $error("en bit");
  sw_bit_a: assert property (ctrlWrEn |=> sw == $past(ctrlWrData[13]))
    else $error("swap bit");
  tp_bit_a: assert property (ctrlWrEn |=> tp == $past(ctrlWrData[12]))
    else $error("topology bit");
  pin_off_a: assert property (!en |=> !rfCtrlOutOe && !rf_ctrl_out)
    else $error("pin not released");
  pin_on_a: assert property (en |=> rfCtrlOutOe)
    else $error("pin not driven");
  tx_wins_a: assert property (txActive |=> st == 3'h4)
    else $error("state");
  one_lvl_a: assert property (en && tp |=> rf_ctrl_out == $past(st[2]))
    else $error("single level");
  two_lvl_a: assert property (en && !tp && !st[0] |=> rf_ctrl_out == $past(st[2] ^ sw))
    else $error("dual level");
  idle_lo_a: assert property (st[0] |=> !rf_ctrl_out)
    else $error("idle level");
  cover property (tp && st[2] && rf_ctrl_out);
  cover property (sw && !tp && st[1] && rf_ctrl_out);
  cover property (en && st[0] && rfCtrlOutOe);
endmodule // rfbc_chk
bind rfbc_bias_ctrl rfbc_chk chk (.*);
`default_nettype wire

// ### test_rf_front_end_bias_control.sv
`timescale 1ns/10ps
`default_nettype none
module test_rf_front_end_bias_control;
  logic       core_clk = 1'h0, rst = 1'h1, ctrlWrEn = 1'h0, rxActive = 1'h0, txActive = 1'h0;
  logic [15:0] ctrlWrData = 16'h0000;
  wire        rf_ctrl_out, rfCtrlOutOe, rf_ctrl_out_enable, pinLvl;
  wire        rf_ctrl_out_polarity_swap, port_topology_select;
  wire [2:0]  activityState;
  int         num_errors = 0, cmp_count = 0, cyc = 0;
  // en swap topo rx tx : oe out
  logic [6:0] rows [12] = '{7'h57, 7'h77, 7'h5A, 7'h7A, 7'h47, 7'h4A, 7'h66, 7'h62,
                            7'h34, 7'h4F, 7'h28, 7'h6B};
  rfbc_bias_ctrl DUT (.*);
  rfbc_far_end far (.core_clk, .outLvl(rf_ctrl_out), .outOe(rfCtrlOutOe), .pinLvl);
  always #50 core_clk = ~core_clk;
  always @(posedge core_clk) if (cyc++ == 200) conclude(1);
  task chk(input logic g, input logic e);
    cmp_count++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch at %0t: got %b expected %b", $time, g, e);
    end
  endtask
  task app(input logic [6:0] r);
    @(posedge core_clk);
    ctrlWrEn <= 1'h1;
    ctrlWrData <= {1'h1, r[6:4], 12'hFFF};
    {rxActive, txActive} <= r[3:2];
    @(posedge core_clk);
    ctrlWrEn <= 1'h0;
    repeat (2) @(posedge core_clk);
    #1;
    chk(rfCtrlOutOe, r[1]);
    chk(r[1] ? pinLvl : rf_ctrl_out, r[0]);
    chk(rf_ctrl_out_enable, r[6]);
    chk(rf_ctrl_out_polarity_swap, r[5]);
    chk(port_topology_select, r[4]);
    chk(activityState == {r[2], r[3] & ~r[2], ~(r[3] | r[2])}, 1'h1);
  endtask
  task conclude(input int t);
    num_errors += t;
    $display("errors %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge core_clk);
    rst <= 1'h0;
    #1;
    chk(rfCtrlOutOe, 1'h0);
    chk(port_topology_select, 1'h0);
    chk(activityState == 3'h1, 1'h1);
    foreach (rows[i]) app(rows[i]);
    @(posedge core_clk) rst <= 1'h1;
    @(posedge core_clk) #1;
    chk(rfCtrlOutOe, 1'h0);
    chk(rf_ctrl_out_enable, 1'h0);
    chk(rf_ctrl_out_polarity_swap, 1'h0);
    @(posedge core_clk) rst <= 1'h0;
    #1;
    chk(rfCtrlOutOe, 1'h0);
    app(rows[0]);
    conclude(0);
  end
endmodule // test_rf_front_end_bias_control
`default_nettype wire
